// file: src/touch_key_pkg.sv
// Purpose: shared constants for the touch-key and converter control slice
// Assumes: pclk at 10 MHz; registers one per aligned APB word
// Notes: register indexes are word numbers; byte address is four times the index
package touch_key_pkg;
    // ---------------------------------------------------------------
    // register indexes and address width
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_FIRST_TOUCH_CHANNEL = 8'ha7;
    localparam logic [7:0] IDX_INTERRUPT_ENABLE_SECOND = 8'ha9;
    localparam logic [7:0] IDX_CONVERTER_RESULT_LOW = 8'haa;
    localparam logic [7:0] IDX_CONVERTER_RESULT_HIGH = 8'hab;
    localparam logic [7:0] IDX_TOUCH_CONTROL = 8'had;
    localparam logic [7:0] IDX_CONVERTER_CHANNEL_SELECT = 8'hae;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'hc0;
    localparam logic [7:0] IDX_EVENT_MASK = 8'hc1;
    localparam logic [7:0] IDX_COMMAND = 8'hc2;
    localparam int ADDR_W = 10;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_CONV_TOUCH_IRQ_ENABLE = 3;
    localparam int BIT_TOUCH_POWER_DOWN = 7;
    localparam int BIT_TOUCH_CONVERSION_DONE = 6;
    localparam int BIT_TOUCH_AUTO_RESTART = 5;
    localparam int BIT_TOUCH_VOLTAGE_SELECT = 4;
    localparam int BIT_TOUCH_EXTERNAL_CAP_SELECT = 3;
    localparam int BIT_IDLE_CHANNEL_DRIVE = 2;
    localparam int BIT_EVENT_TOUCH_DONE = 0;
    localparam int BIT_EVENT_CONVERTER_DONE = 1;
    localparam int BIT_CMD_TOUCH_START = 0;
    localparam int BIT_CMD_CONVERTER_START = 1;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_INTERRUPT_ENABLE_SECOND = 8'h00;
    localparam logic [7:0] RST_TOUCH_CONTROL_RW = 8'h80;
    localparam logic [3:0] RST_CONVERTER_CHANNEL_FIELD = 4'hf;
    localparam logic [4:0] RST_FIRST_TOUCH_CHANNEL = 5'h1f;
    localparam logic [1:0] RST_EVENT_MASK = 2'h0;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TOUCH_PASS_TIME_NS = 10000;
    localparam int TOUCH_PASS_CYCLES = (TOUCH_PASS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PASS_CNT_W = 8;
    typedef enum logic [1:0] {SCAN_ONCE, SCAN_TWICE, SCAN_FOUR, SCAN_EIGHT} touch_scan_repeat_mode_e;
endpackage

// file: src/touch_scan_seq.sv
// Purpose: touch conversion sequencer with repeat passes and auto restart
// Assumes: start is a one-cycle pulse; analog front end paces itself per pass
// Notes: a start while powered down or busy is ignored
`timescale 1ns/10ps
module touch_scan_seq
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    input wire logic power_down,
    input wire logic auto_restart,
    input wire touch_key_pkg::touch_scan_repeat_mode_e mode,
    // status
    output logic busy,
    output logic done,
    output logic done_pulse
);
    import touch_key_pkg::*;

    logic [PASS_CNT_W-1:0] cycle_cnt;
    logic [3:0] passes_left;
    logic launch;
    logic finish;

    // last cycle of the last pass
    assign finish = busy && cycle_cnt == '0 && passes_left == 4'h0;

    // auto restart relaunches in the finishing cycle, so the done flag never blinks high
    assign launch = !power_down && ((start && !busy) || (finish && auto_restart));

    // pass counter: 1, 2, 4 or 8 passes of fixed length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            cycle_cnt <= '0;
            passes_left <= 4'h0;
        end
        else if (power_down)
        begin
            busy <= 1'b0;
            cycle_cnt <= '0;
            passes_left <= 4'h0;
        end
        else if (launch)
        begin
            busy <= 1'b1;
            cycle_cnt <= PASS_CNT_W'(TOUCH_PASS_CYCLES - 1);
            passes_left <= 4'(1 << mode) - 4'h1;
        end
        else if (busy && cycle_cnt == '0)
        begin
            if (passes_left == 4'h0)
            begin
                busy <= 1'b0;
            end
            else
            begin
                passes_left <= passes_left - 4'h1;
                cycle_cnt <= PASS_CNT_W'(TOUCH_PASS_CYCLES - 1);
            end
        end
        else if (busy)
        begin
            cycle_cnt <= cycle_cnt - PASS_CNT_W'(1);
        end
    end

    // completion flag: low while running, high when finished
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done <= 1'b1;
            done_pulse <= 1'b0;
        end
        else
        begin
            done <= !(launch || (busy && !(cycle_cnt == '0 && passes_left == 4'h0)));
            done_pulse <= busy && !power_down && cycle_cnt == '0 && passes_left == 4'h0;
        end
    end

    // total busy time equals passes times pass length
    logic [11:0] busy_len;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_len <= 12'h000;
        else
            busy_len <= launch ? 12'h000 : (busy ? busy_len + 12'h001 : 12'h000);
    end

    scan_length_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!$past(power_down) && $fell(busy) && !power_down |->
            $past(busy_len) + 12'h001 == 12'((1 << mode) * TOUCH_PASS_CYCLES)))
        else $error("touch conversion length does not match repeat mode");
    done_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |-> !done)
        else $error("completion flag high while converting");
endmodule // touch_scan_seq

// file: src/touch_key_adc_control.sv
// Purpose: APB register slice for touch-key scanning and converter control
// Assumes: converter and touch front end run on pclk; APB master holds requests
// Notes: registers answer with pready in the first access cycle
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module touch_key_adc_control
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [touch_key_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // touch front end
    output logic touch_power_down,
    output logic touch_voltage_high,
    output logic touch_idle_shield,
    output logic touch_scan_active,
    output logic [4:0] touch_scan_channel,
    // converter front end
    output logic [3:0] converter_channel,
    output logic converter_start,
    input wire logic converter_done,
    input wire logic [11:0] converter_data
);
    import touch_key_pkg::*;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] interrupt_enable_second;
    logic [7:0] touch_control;
    logic [3:0] converter_channel_field;
    logic [4:0] first_touch_channel;
    logic [11:0] result;
    logic [1:0] event_status;
    logic [1:0] event_mask;
    logic touch_busy;
    logic touch_conversion_done;
    logic touch_done_pulse;
    logic touch_start_conversion;

    logic setup;
    logic access;
    logic wr_en;
    logic rd_en;
    logic [7:0] index;
    logic mapped;
    logic [7:0] read_value;

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign index = paddr[ADDR_W-1:2];
    assign wr_en = access && pwrite && pstrb[0] && !pslverr;
    assign rd_en = access && !pwrite && !pslverr;

    // ---------------------------------------------------------------
    // address decode and read mux
    // ---------------------------------------------------------------
    // reads are sampled at setup so prdata can come from a flop
    always_comb
    begin
        mapped = 1'b1;
        read_value = 8'h00;
        case (index)
            IDX_FIRST_TOUCH_CHANNEL: read_value = {3'h0, first_touch_channel};
            IDX_INTERRUPT_ENABLE_SECOND: read_value = interrupt_enable_second;
            IDX_CONVERTER_RESULT_LOW: read_value = {result[3:0], 4'h0};
            IDX_CONVERTER_RESULT_HIGH: read_value = result[11:4];
            IDX_TOUCH_CONTROL: read_value = {touch_control[7], touch_conversion_done,
                touch_control[5:0]};
            IDX_CONVERTER_CHANNEL_SELECT: read_value = {converter_channel_field, 4'h0};
            IDX_EVENT_STATUS: read_value = {6'h00, event_status};
            IDX_EVENT_MASK: read_value = {6'h00, event_mask};
            IDX_COMMAND: read_value = 8'h00;
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00)
        begin
            mapped = 1'b0;
        end
    end

    // one wait-free access phase; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (setup)
        begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= (mapped && !pwrite) ? {24'h00_0000, read_value} : 32'h0000_0000;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // software-written registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_enable_second <= RST_INTERRUPT_ENABLE_SECOND;
            touch_control <= RST_TOUCH_CONTROL_RW;
            converter_channel_field <= RST_CONVERTER_CHANNEL_FIELD;
            first_touch_channel <= RST_FIRST_TOUCH_CHANNEL;
            event_mask <= RST_EVENT_MASK;
        end
        else if (wr_en)
        begin
            case (index)
                IDX_INTERRUPT_ENABLE_SECOND: interrupt_enable_second <= pwdata[7:0];
                // bit 6 is the read-only done flag and is not stored
                IDX_TOUCH_CONTROL: touch_control <= pwdata[7:0] & 8'hbf;
                IDX_CONVERTER_CHANNEL_SELECT: converter_channel_field <= pwdata[7:4];
                IDX_FIRST_TOUCH_CHANNEL: first_touch_channel <= pwdata[4:0];
                IDX_EVENT_MASK: event_mask <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // command strobes last one cycle after the write edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            touch_start_conversion <= 1'b0;
            converter_start <= 1'b0;
        end
        else
        begin
            touch_start_conversion <= wr_en && index == IDX_COMMAND && pwdata[BIT_CMD_TOUCH_START];
            converter_start <= wr_en && index == IDX_COMMAND && pwdata[BIT_CMD_CONVERTER_START];
        end
    end

    // ---------------------------------------------------------------
    // touch sequencer
    // ---------------------------------------------------------------
    touch_scan_seq u_seq
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(touch_start_conversion),
        .power_down(touch_control[BIT_TOUCH_POWER_DOWN]),
        .auto_restart(touch_control[BIT_TOUCH_AUTO_RESTART]),
        .mode(touch_scan_repeat_mode_e'(touch_control[1:0])),
        .busy(touch_busy),
        .done(touch_conversion_done),
        .done_pulse(touch_done_pulse)
    );

    // ---------------------------------------------------------------
    // front-end drive
    // ---------------------------------------------------------------
    // idle channels return to ground as soon as the conversion ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            touch_power_down <= 1'b1;
            touch_voltage_high <= 1'b0;
            touch_idle_shield <= 1'b0;
            touch_scan_active <= 1'b0;
            touch_scan_channel <= RST_FIRST_TOUCH_CHANNEL;
            converter_channel <= RST_CONVERTER_CHANNEL_FIELD;
        end
        else
        begin
            touch_power_down <= touch_control[BIT_TOUCH_POWER_DOWN];
            touch_voltage_high <= touch_control[BIT_TOUCH_VOLTAGE_SELECT];
            touch_idle_shield <= touch_control[BIT_IDLE_CHANNEL_DRIVE] && touch_busy;
            touch_scan_active <= touch_busy;
            touch_scan_channel <= first_touch_channel;
            converter_channel <= converter_channel_field;
        end
    end

    // result captured when the converter reports completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result <= 12'h000;
        else if (converter_done)
            result <= converter_data;
    end

    // ---------------------------------------------------------------
    // events and interrupt
    // ---------------------------------------------------------------
    // read clears; a new event in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_status <= 2'h0;
        else
            event_status <= (rd_en && index == IDX_EVENT_STATUS ? 2'h0 : event_status)
                | {converter_done, touch_done_pulse};
    end

    // shared source gated by the enable bit as well as the mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(event_status & event_mask)
                && interrupt_enable_second[BIT_CONV_TOUCH_IRQ_ENABLE];
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(interrupt_enable_second[BIT_CONV_TOUCH_IRQ_ENABLE])
            && $past(|(event_status & event_mask)))
        else $error("interrupt raised while masked");
    power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        touch_power_down |-> ##1 !touch_busy)
        else $error("touch scan running while powered down");
    done_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && index == IDX_TOUCH_CONTROL |=>
            prdata[BIT_TOUCH_CONVERSION_DONE] == $past(touch_conversion_done))
        else $error("done flag read back wrong");
    restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        touch_done_pulse && touch_control[BIT_TOUCH_AUTO_RESTART]
            && !touch_control[BIT_TOUCH_POWER_DOWN] |=> touch_busy)
        else $error("auto restart did not relaunch");
    no_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        touch_done_pulse && !touch_control[BIT_TOUCH_AUTO_RESTART]
            && !touch_start_conversion |=> !touch_busy)
        else $error("conversion repeated without start");
    voltage_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 touch_voltage_high == $past(touch_control[BIT_TOUCH_VOLTAGE_SELECT]))
        else $error("voltage select not applied");
    shield_a: assert property (@(posedge pclk) disable iff (!presetn)
        touch_idle_shield |-> touch_scan_active && $past(touch_control[BIT_IDLE_CHANNEL_DRIVE]))
        else $error("idle channels shielded outside a scan");
    channel_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(converter_channel_field) |=> converter_channel == $past(converter_channel_field))
        else $error("converter channel not routed");
    result_split_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && index == IDX_CONVERTER_RESULT_HIGH |=> prdata[7:0] == $past(result[11:4]))
        else $error("result high byte wrong");
endmodule // touch_key_adc_control

// file: tb/converter_model.sv
// Purpose: converter front end model answering start pulses
// Assumes: same clock as the control slice
// Notes: data is only meaningful with the done pulse; it toggles otherwise
`timescale 1ns/10ps
module converter_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // converter handshake
    input wire logic converter_start,
    output logic converter_done,
    output logic [11:0] converter_data,
    // bench settings
    input wire logic [11:0] sample,
    input wire logic [7:0] delay
);
    // ---------------------------------------------------------------
    // conversion timer
    // ---------------------------------------------------------------
    logic [8:0] left;
    // toggling data when idle so a stale capture never looks right
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left <= 9'h000;
            converter_done <= 1'b0;
            converter_data <= 12'h000;
        end
        else
        begin
            converter_done <= 1'b0;
            if (converter_start)
                left <= {1'b0, delay} + 9'h001;
            else if (left != 9'h000)
                left <= left - 9'h001;
            if (left == 9'h001)
            begin
                converter_done <= 1'b1;
                converter_data <= sample;
            end
            else
                converter_data <= ~converter_data;
        end
    end
endmodule // converter_model

// file: tb/touch_key_adc_control_test.sv
// Purpose: self-checking bench for the touch-key and converter slice
// Assumes: apb answers are awaited with a bound; seed fixed
// Notes: software-side limits are kept by the stimulus itself
`timescale 1ns/10ps
module touch_key_adc_control_test;
    import touch_key_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb, converter_channel, ch;
    logic touch_power_down, touch_voltage_high, touch_idle_shield, touch_scan_active;
    logic [4:0] touch_scan_channel, fc;
    logic converter_start, converter_done, rerr, vh, sh;
    logic [11:0] converter_data, sample;
    logic [7:0] delay, tc;
    int errors, samples_checked, n;

    touch_key_adc_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .touch_power_down(touch_power_down), .touch_voltage_high(touch_voltage_high),
        .touch_idle_shield(touch_idle_shield), .touch_scan_active(touch_scan_active),
        .touch_scan_channel(touch_scan_channel), .converter_channel(converter_channel),
        .converter_start(converter_start), .converter_done(converter_done),
        .converter_data(converter_data));
    converter_model pm_u (.pclk(pclk), .presetn(presetn), .converter_start(converter_start),
        .converter_done(converter_done), .converter_data(converter_data), .sample(sample),
        .delay(delay));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] pass_len(input int m);
        return 32'(TOUCH_PASS_CYCLES) << m;
    endfunction

    task automatic results();
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready is taken at the rising edge, as the slave's flops see it
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            results();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rdat, exp);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    // ---------------------------------------------------------------
    // clock and watchdog
    // ---------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        repeat (100000) @(posedge pclk);
        errors++;
        results();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h00000000;
        pstrb = 4'hf;
        sample = 12'h000;
        delay = 8'h00;
        errors = 0;
        samples_checked = 0;
        void'($urandom(28434));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(touch_power_down, 1'b1);
        chk(converter_channel, 4'hf);
        chk(touch_scan_channel, 5'h1f);
        rd(IDX_TOUCH_CONTROL, 32'hc0);
        rd(IDX_INTERRUPT_ENABLE_SECOND, 32'h00);
        rd(IDX_CONVERTER_CHANNEL_SELECT, 32'hf0);
        rd(IDX_FIRST_TOUCH_CHANNEL, 32'h1f);
        apb(1'b0, 8'h10, 8'h00);
        chk(rerr, 1'b1);
        // every scan mode once, with random voltage and idle drive
        for (int m = 0; m < 4; m++)
        begin
            vh = 1'($urandom_range(1));
            sh = 1'($urandom_range(1));
            ch = 4'($urandom_range(7));
            fc = (m == 3) ? 5'h17 : 5'($urandom_range(19));
            tc = {3'b000, vh, 1'b0, sh, 2'(m)};
            wr(IDX_TOUCH_CONTROL, tc);
            wr(IDX_CONVERTER_CHANNEL_SELECT, {ch, 4'h0});
            wr(IDX_FIRST_TOUCH_CHANNEL, {3'b000, fc});
            settle();
            chk(touch_power_down, 1'b0);
            chk(touch_voltage_high, vh);
            chk(converter_channel, ch);
            chk(touch_scan_channel, fc);
            rd(IDX_TOUCH_CONTROL, {24'h0, tc | 8'h40});
            wr(IDX_COMMAND, 8'h01);
            n = 0;
            while (touch_scan_active !== 1'b1 && n < 10)
            begin
                @(negedge pclk);
                n++;
            end
            chk(touch_idle_shield, sh);
            n = 0;
            while (touch_scan_active === 1'b1 && n < 2000)
            begin
                @(negedge pclk);
                n++;
            end
            chk(n, pass_len(m));
            chk(touch_idle_shield, 1'b0);
            rd(IDX_EVENT_STATUS, 32'h01);
            repeat (20) @(negedge pclk);
            chk(touch_scan_active, 1'b0);
        end
        // one start keeps scanning; powering down stops it
        wr(IDX_TOUCH_CONTROL, 8'h20);
        wr(IDX_COMMAND, 8'h01);
        repeat (350) @(negedge pclk);
        chk(touch_scan_active, 1'b1);
        rd(IDX_TOUCH_CONTROL, 32'h20);
        wr(IDX_TOUCH_CONTROL, 8'ha0);
        settle();
        chk(touch_scan_active, 1'b0);
        chk(touch_power_down, 1'b1);
        // converter results, prompt then slow, with the interrupt gate
        wr(IDX_EVENT_MASK, 8'h02);
        apb(1'b0, IDX_EVENT_STATUS, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            sample <= 12'($urandom);
            delay <= (k == 0) ? 8'h00 : 8'h40;
            wr(IDX_INTERRUPT_ENABLE_SECOND, 8'h00);
            wr(IDX_COMMAND, 8'h02);
            repeat (80) @(negedge pclk);
            chk(irq, 1'b0);
            wr(IDX_INTERRUPT_ENABLE_SECOND, 8'h08);
            rd(IDX_INTERRUPT_ENABLE_SECOND, 32'h08);
            chk(irq, 1'b1);
            rd(IDX_CONVERTER_RESULT_HIGH, {24'h0, sample[11:4]});
            rd(IDX_CONVERTER_RESULT_LOW, {24'h0, sample[3:0], 4'h0});
            rd(IDX_EVENT_STATUS, 32'h02);
            settle();
            chk(irq, 1'b0);
        end
        results();
    end
endmodule // touch_key_adc_control_test
